// ==== rtl/fma_pkg.sv ====
// Constants and helpers for the fused multiply-add unit
package fma_pkg;
	localparam int VEC_W = 256;
	localparam int HALF_W = 128;
	localparam int SP_W = 32;
	localparam int DP_W = 64;
	localparam int SP_EW = 8;
	localparam int SP_FW = 23;
	localparam int DP_EW = 11;
	localparam int DP_FW = 52;
	localparam int SP_LANES = VEC_W / SP_W;
	localparam int DP_LANES = VEC_W / DP_W;
	localparam int HALF_SP = HALF_W / SP_W;
	localparam int DP_PER = DP_W / SP_W;
	localparam int IDX_W = 5;
	localparam int XW = 16;
	// Order code: three two-bit digits, multiplicand digit on top
	localparam int ORD_W = 6;
	localparam int DIG_W = 2;
	localparam int MC_POS = 4;
	localparam int MP_POS = 2;
	localparam int AD_POS = 0;
	localparam logic [1:0] DIG_SRC1 = 2'h1;
	localparam logic [1:0] DIG_SRC2 = 2'h2;
	localparam logic [1:0] DIG_SRC3 = 2'h3;
	// Form bits
	localparam int FORM_NEG = 1;
	localparam int FORM_SUB = 0;
	localparam logic [1:0] FORM_MADD = 2'h0;
	localparam logic [1:0] FORM_MSUB = 2'h1;
	// Rounding-control field encodings
	localparam logic [1:0] RM_NEAR = 2'h0;
	localparam logic [1:0] RM_DOWN = 2'h1;
	localparam logic [1:0] RM_UP = 2'h2;
	localparam logic [1:0] RM_ZERO = 2'h3;
	// Double-precision values
	localparam logic [DP_W-1:0] DP_DNAN = 64'hfff8000000000000;
	localparam logic [DP_W-1:0] DP_QBIT = 64'h0008000000000000;
	localparam logic [DP_W-1:0] DP_NZERO = 64'h8000000000000000;
	localparam logic [DP_W-1:0] DP_ONE = 64'h3ff0000000000000;
	localparam logic [DP_W-1:0] DP_NEG_ONE = 64'hbff0000000000000;
	localparam logic [DP_W-1:0] DP_ONE_UP = 64'h3ff0000000000001;
	localparam logic [DP_W-1:0] DP_ONE_DN = 64'h3fefffffffffffff;

	function automatic logic dp_nan(input logic [DP_W-1:0] v);
		return (&v[DP_W-2 -: DP_EW]) & (|v[DP_FW-1:0]);
	endfunction

	function automatic logic dp_signaling_nan(input logic [DP_W-1:0] v);
		return dp_nan(v) & ~v[DP_FW-1];
	endfunction

	function automatic logic dp_inf(input logic [DP_W-1:0] v);
		return (&v[DP_W-2 -: DP_EW]) & ~(|v[DP_FW-1:0]);
	endfunction

	function automatic logic dp_zero(input logic [DP_W-1:0] v);
		return ~(|v[DP_W-2:0]);
	endfunction
endpackage

// ==== rtl/fma_lane_if.sv ====
// Operand and result carrier for one fused multiply-add lane
`timescale 1ns/1ps
interface fma_lane_if #(parameter int DW = 32);
	logic [DW-1:0] x;
	logic [DW-1:0] y;
	logic [DW-1:0] z;
	logic          neg_prod;
	logic          sub_add;
	logic [1:0]    rmode;
	logic [DW-1:0] r;
	logic          inval;
	modport unit (output x, y, z, neg_prod, sub_add, rmode, input r, inval);
	modport lane (input x, y, z, neg_prod, sub_add, rmode, output r, inval);
endinterface

// ==== rtl/fma_lane.sv ====
// One fused multiply-add lane with a single final rounding
`timescale 1ns/1ps
module fma_lane import fma_pkg::*; #(
	parameter int EW = SP_EW,
	parameter int FW = SP_FW
) (
	// Operands and result
	fma_lane_if.lane ln
);
	localparam int DW = EW + FW + 1;
	localparam int F2 = FW + 1;
	localparam int G = 2 * F2 + 2;
	localparam int W = 2 * F2 + G + 1;
	localparam logic signed [XW-1:0] PSHIFT = XW'((1 << (EW - 1)) - 1 + FW);
	localparam logic signed [XW-1:0] NORM = XW'(FW + G);
	localparam logic signed [XW-1:0] EMAX = XW'((1 << EW) - 1);
	localparam logic signed [XW-1:0] WTOP = XW'(W - 1);
	localparam logic signed [XW-1:0] ONE = XW'(1);
	localparam logic [DW-1:0] QBIT = DW'(1) << (FW - 1);
	localparam logic [DW-1:0] DNAN = {1'b1, {EW{1'b1}}, 1'b1, {(FW - 1){1'b0}}};
	localparam logic [DW-2:0] INF = {{EW{1'b1}}, {FW{1'b0}}};
	localparam logic [DW-2:0] MAXF = {{(EW - 1){1'b1}}, 1'b0, {FW{1'b1}}};

	// Operand decode: 0 multiplicand, 1 multiplier, 2 addend
	logic [DW-1:0]         op [3];
	logic [F2-1:0]         man [3];
	logic signed [XW-1:0]  ex [3];
	logic [2:0]            sgn;
	logic [2:0]            isnan;
	logic [2:0]            issnan;
	logic [2:0]            isinf;
	logic [2:0]            iszero;
	assign op[0] = ln.x;
	assign op[1] = ln.y;
	assign op[2] = ln.z;
	for (genvar k = 0; k < 3; k++) begin : g_dec
		wire [EW-1:0] ef = op[k][DW-2 -: EW];
		wire [FW-1:0] ff = op[k][FW-1:0];
		assign sgn[k] = op[k][DW-1];
		assign isnan[k] = (&ef) & (|ff);
		assign issnan[k] = isnan[k] & ~ff[FW-1];
		assign isinf[k] = (&ef) & ~(|ff);
		assign iszero[k] = ~(|ef) & ~(|ff);
		assign man[k] = {|ef, ff};
		assign ex[k] = XW'({ef[EW-1:1], ef[0] | ~(|ef)});
	end

	// Exact product and alignment
	wire                  sp = sgn[0] ^ sgn[1] ^ ln.neg_prod;
	wire                  sz = sgn[2] ^ ln.sub_add;
	wire [2*F2-1:0]       prod = man[0] * man[1];
	wire                  pz = ~(|prod);
	wire                  zz = ~(|man[2]);
	wire signed [XW-1:0]  ep = ex[0] + ex[1] - PSHIFT;
	wire signed [XW-1:0]  eb = pz ? ex[2] : ((zz || ep > ex[2]) ? ep : ex[2]);
	wire [XW-1:0]         dp = eb - ep;
	wire [XW-1:0]         dz = eb - ex[2];
	wire [W-1:0]          pf = {1'b0, prod, {G{1'b0}}};
	wire [W-1:0]          zf = W'({man[2], {G{1'b0}}});
	wire [W-1:0]          pa = (pf >> dp) | W'(|(pf & ~({W{1'b1}} << dp)));
	wire [W-1:0]          za = (zf >> dz) | W'(|(zf & ~({W{1'b1}} << dz)));
	wire                  pbig = pa >= za;
	wire [W-1:0]          sum = (sp == sz) ? pa + za : (pbig ? pa - za : za - pa);
	wire                  rs = (sp == sz || pbig) ? sp : sz;

	// Leading one
	logic [XW-1:0] lead;
	always_comb begin
		lead = '0;
		for (int i = 0; i < W; i++) begin
			if (sum[i]) begin
				lead = XW'(i);
			end
		end
	end

	// Normalise, then round once
	wire signed [XW-1:0]  re = eb + $signed(lead) - NORM;
	wire                  tiny = re < ONE;
	wire signed [XW-1:0]  lsh0 = WTOP - $signed(lead);
	wire signed [XW-1:0]  lsh = tiny ? lsh0 + re - ONE : lsh0;
	wire [XW-1:0]         rsh = -lsh;
	wire [W-1:0]          nrm = lsh[XW-1] ? (sum >> rsh) : (sum << lsh);
	wire                  lost = lsh[XW-1] & (|(sum & ~({W{1'b1}} << rsh)));
	wire [F2-1:0]         mant = nrm[W-1 -: F2];
	wire                  grd = nrm[W-1-F2];
	wire                  stk = (|nrm[W-2-F2:0]) | lost;
	wire                  inexact = grd | stk;
	wire                  inc = (ln.rmode == RM_NEAR) ? grd & (stk | mant[0]) :
	                            (ln.rmode == RM_DOWN) ? inexact & rs :
	                            (ln.rmode == RM_UP) ? inexact & ~rs : 1'b0;
	wire [XW-1:0]         efld = tiny ? '0 : re;
	wire [XW+FW-1:0]      rnd = {efld, mant[FW-1:0]} + (XW + FW)'(inc);
	wire [XW-1:0]         rexp = rnd[XW+FW-1:FW];
	wire                  ovf = $signed(rexp) >= EMAX;
	wire                  to_inf = (ln.rmode == RM_NEAR) | ((ln.rmode == RM_DOWN) & rs) |
	                               ((ln.rmode == RM_UP) & ~rs);
	wire [DW-1:0]         fin = !ovf ? {rs, rexp[EW-1:0], rnd[FW-1:0]} :
	                            (to_inf ? {rs, INF} : {rs, MAXF});
	wire                  zsg = (sp == sz) ? sp : (ln.rmode == RM_DOWN);

	// Special operands
	wire                  anynan = |isnan;
	wire                  pinf = isinf[0] | isinf[1];
	wire                  pinv = (isinf[0] & iszero[1]) | (iszero[0] & isinf[1]);
	wire                  icnl = pinf & isinf[2] & (sp != sz);
	wire [DW-1:0]         quiet_nan = isnan[0] ? (op[0] | QBIT) :
	                             isnan[1] ? (op[1] | QBIT) : (op[2] | QBIT);

	assign ln.r = anynan ? quiet_nan :
	              (pinv | icnl) ? DNAN :
	              pinf ? {sp, INF} :
	              isinf[2] ? {sz, INF} :
	              ~(|sum) ? {zsg, {(DW - 1){1'b0}}} : fin;
	assign ln.inval = anynan ? (|issnan) : (pinv | icnl);
endmodule

// ==== rtl/fma_unit.sv ====
// Fused multiply-add execution unit for packed and scalar vectors
`timescale 1ns/1ps
module fma_unit import fma_pkg::*; (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// Issue from decoder and register file
	input  wire logic               op_valid,
	input  wire logic [ORD_W-1:0]   order_code,
	input  wire logic [1:0]         form,
	input  wire logic               dbl,
	input  wire logic               packed_op,
	input  wire logic               wide,
	input  wire logic [1:0]         round_mode,
	input  wire logic [IDX_W-1:0]   src1_idx,
	input  wire logic [VEC_W-1:0]   src1,
	input  wire logic [VEC_W-1:0]   src2,
	input  wire logic [VEC_W-1:0]   src3,
	// Result write-back and status
	output logic                    res_valid,
	output logic [IDX_W-1:0]        res_dest_idx,
	output logic [VEC_W-1:0]        res_data,
	output logic                    invalid_operation_flag
);
	// Operand routing by order digits
	wire [DIG_W-1:0]  mc_dig = order_code[MC_POS +: DIG_W];
	wire [DIG_W-1:0]  mp_dig = order_code[MP_POS +: DIG_W];
	wire [DIG_W-1:0]  ad_dig = order_code[AD_POS +: DIG_W];
	wire [VEC_W-1:0]  mc_v = (mc_dig == DIG_SRC1) ? src1 :
	                         (mc_dig == DIG_SRC2) ? src2 : src3;
	wire [VEC_W-1:0]  mp_v = (mp_dig == DIG_SRC1) ? src1 :
	                         (mp_dig == DIG_SRC2) ? src2 : src3;
	wire [VEC_W-1:0]  ad_v = (ad_dig == DIG_SRC1) ? src1 :
	                         (ad_dig == DIG_SRC2) ? src2 : src3;

	// Lane results and merge
	wire [VEC_W-1:0]     s_res;
	wire [VEC_W-1:0]     d_res;
	wire [VEC_W-1:0]     merged;
	wire [SP_LANES-1:0]  act;
	wire [SP_LANES-1:0]  s_inv;
	wire [DP_LANES-1:0]  d_inv;

	for (genvar i = 0; i < SP_LANES; i++) begin : g_sp
		fma_lane_if #(.DW(SP_W)) sif ();
		assign sif.x = mc_v[i*SP_W +: SP_W];
		assign sif.y = mp_v[i*SP_W +: SP_W];
		assign sif.z = ad_v[i*SP_W +: SP_W];
		assign sif.neg_prod = form[FORM_NEG];
		assign sif.sub_add = form[FORM_SUB];
		assign sif.rmode = round_mode;
		fma_lane #(.EW(SP_EW), .FW(SP_FW)) u_lane (.ln(sif));
		assign s_res[i*SP_W +: SP_W] = sif.r;
		assign s_inv[i] = sif.inval & act[i];
		assign act[i] = packed_op ? (wide | (i < HALF_SP)) :
		                (dbl ? (i < DP_PER) : (i == 0));
		assign merged[i*SP_W +: SP_W] = act[i] ?
		                (dbl ? d_res[i*SP_W +: SP_W] : s_res[i*SP_W +: SP_W]) :
		                ((i < HALF_SP) ? src1[i*SP_W +: SP_W] : '0);
	end

	for (genvar j = 0; j < DP_LANES; j++) begin : g_dp
		fma_lane_if #(.DW(DP_W)) dif ();
		assign dif.x = mc_v[j*DP_W +: DP_W];
		assign dif.y = mp_v[j*DP_W +: DP_W];
		assign dif.z = ad_v[j*DP_W +: DP_W];
		assign dif.neg_prod = form[FORM_NEG];
		assign dif.sub_add = form[FORM_SUB];
		assign dif.rmode = round_mode;
		fma_lane #(.EW(DP_EW), .FW(DP_FW)) u_lane (.ln(dif));
		assign d_res[j*DP_W +: DP_W] = dif.r;
		assign d_inv[j] = dif.inval & act[j*DP_PER];
	end

	wire inval_any = dbl ? (|d_inv) : (|s_inv);

	// Result register
	logic                res_valid_ff;
	logic [IDX_W-1:0]    res_dest_ff;
	logic [VEC_W-1:0]    res_data_ff;
	logic                inval_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_valid_ff <= 1'b0;
			res_dest_ff <= '0;
			res_data_ff <= '0;
			inval_ff <= 1'b0;
		end else begin
			res_valid_ff <= op_valid;
			inval_ff <= op_valid & inval_any;
			if (op_valid) begin
				res_dest_ff <= src1_idx;
				res_data_ff <= merged;
			end
		end
	end

	assign res_valid = res_valid_ff;
	assign res_dest_idx = res_dest_ff;
	assign res_data = res_data_ff;
	assign invalid_operation_flag = inval_ff;

	// Checks on write-back, scalar merge and double lane 0
	wire [DP_W-1:0]  m0 = mc_v[DP_W-1:0];
	wire [DP_W-1:0]  p0 = mp_v[DP_W-1:0];
	wire [DP_W-1:0]  a0 = ad_v[DP_W-1:0];
	wire             pk_d = op_valid & dbl & packed_op;
	wire             ps0 = m0[DP_W-1] ^ p0[DP_W-1] ^ form[FORM_NEG];
	wire             zs0 = a0[DP_W-1] ^ form[FORM_SUB];
	wire             all_z0 = dp_zero(m0) & dp_zero(p0) & dp_zero(a0);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	dest_write_a: assert property (
		op_valid |=> res_valid && res_dest_idx == $past(src1_idx))
		else $error("result not returned to first source index");
	idle_quiet_a: assert property (
		!op_valid |=> !res_valid && !invalid_operation_flag)
		else $error("result or flag without an operation");
	scalar_upper_a: assert property (
		op_valid && !packed_op |=> res_data[VEC_W-1:HALF_W] == '0)
		else $error("scalar upper half not cleared");
	scalar_keep_a: assert property (
		op_valid && !packed_op && !dbl
		|=> res_data[HALF_W-1:SP_W] == $past(src1[HALF_W-1:SP_W]))
		else $error("scalar lower elements not kept");
	nan_order_a: assert property (
		pk_d && dp_nan(m0) |=> res_data[DP_W-1:0] == ($past(m0) | DP_QBIT))
		else $error("multiplicand NaN not chosen");
	nan_quiet_a: assert property (
		pk_d && !dp_nan(m0) && dp_nan(p0)
		|=> res_data[DP_W-1:0] == ($past(p0) | DP_QBIT))
		else $error("multiplier NaN not quieted or not chosen");
	signaling_nan_flag_a: assert property (
		pk_d && (dp_signaling_nan(m0) || dp_signaling_nan(p0) || dp_signaling_nan(a0)) |=> invalid_operation_flag)
		else $error("signaling NaN did not raise invalid");
	inf_zero_a: assert property (
		pk_d && dp_inf(m0) && dp_zero(p0) && !dp_nan(a0)
		|=> res_data[DP_W-1:0] == DP_DNAN && invalid_operation_flag)
		else $error("infinity times zero not invalid");
	inf_cancel_a: assert property (
		pk_d && dp_inf(m0) && dp_inf(p0) && dp_inf(a0) && ps0 != zs0
		|=> res_data[DP_W-1:0] == DP_DNAN && invalid_operation_flag)
		else $error("opposite infinities not default NaN");
	zero_same_a: assert property (
		pk_d && all_z0 && ps0 == zs0
		|=> res_data[DP_W-1:0] == ($past(ps0) ? DP_NZERO : '0))
		else $error("same-sign zero sum has wrong sign");
	zero_round_a: assert property (
		pk_d && all_z0 && ps0 != zs0
		|=> res_data[DP_W-1:0] == (($past(round_mode) == RM_DOWN) ? DP_NZERO : '0))
		else $error("opposite zero sum has wrong sign");
	form_sign_a: assert property (
		pk_d && m0 == DP_ONE && p0 == DP_ONE && a0 == '0
		|=> res_data[DP_W-1:0] == ($past(form[FORM_NEG]) ? DP_NEG_ONE : DP_ONE))
		else $error("product sign not set by form");
	single_round_a: assert property (
		pk_d && m0 == DP_ONE_UP && p0 == DP_ONE_DN && a0 == DP_ONE
		&& form == FORM_MSUB && round_mode == RM_NEAR
		|=> res_data[DP_W-2:0] != '0 && !res_data[DP_W-1])
		else $error("product rounded before the subtraction");

	pk_double_c: cover property (op_valid && packed_op && dbl && wide);
	pk_single_c: cover property (op_valid && packed_op && !dbl && wide);
	scalar_c: cover property (op_valid && !packed_op);
	invalid_c: cover property (invalid_operation_flag);
endmodule

// ==== bench/fma_rf_model.sv ====
// Register file and issue side model facing the fused multiply-add unit
`timescale 1ns/1ps
module fma_rf_model import fma_pkg::*; (
	// Clock
	input  wire logic             clk,
	// Operand indices
	input  wire logic [IDX_W-1:0] idx1,
	input  wire logic [IDX_W-1:0] idx2,
	input  wire logic [IDX_W-1:0] idx3,
	// Operand read
	output logic      [VEC_W-1:0] src1,
	output logic      [VEC_W-1:0] src2,
	output logic      [VEC_W-1:0] src3,
	// Result write-back
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [VEC_W-1:0] wr_data
);
	logic [VEC_W-1:0] regs_ff [32];

	// Operand 1 doubles as destination
	assign src1 = regs_ff[idx1];
	assign src2 = regs_ff[idx2];
	assign src3 = regs_ff[idx3];

	always @(posedge clk) begin
		if (wr_en) begin
			regs_ff[wr_idx] <= wr_data;
		end
	end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench for the fused multiply-add unit
`timescale 1ns/1ps
module tb_top import fma_pkg::*;;
	localparam logic [63:0] D2 = 64'h4000000000000000;
	localparam logic [63:0] D3 = 64'h4008000000000000;
	localparam logic [63:0] D5 = 64'h4014000000000000;
	localparam logic [31:0] S2 = 32'h40000000;
	localparam logic [31:0] S3 = 32'h40400000;
	localparam logic [31:0] S5 = 32'h40a00000;
	localparam logic [63:0] DINF = 64'h7ff0000000000000;
	localparam logic [63:0] DSN = 64'h7ff0000000000001;
	localparam logic [63:0] DQN = 64'h7ff8000000000002;
	localparam int WD_CYC = 2000;

	logic                clk;
	logic                resetn;
	logic                op_valid;
	logic [ORD_W-1:0]    order_code;
	logic [1:0]          form;
	logic [1:0]          round_mode;
	logic                dbl;
	logic                packed_op;
	logic                wide;
	logic [IDX_W-1:0]    i1;
	logic [IDX_W-1:0]    i2;
	logic [IDX_W-1:0]    i3;
	logic [VEC_W-1:0]    s1;
	logic [VEC_W-1:0]    s2;
	logic [VEC_W-1:0]    s3;
	logic                res_valid;
	logic [IDX_W-1:0]    res_dest_idx;
	logic [VEC_W-1:0]    res_data;
	logic                flag;
	int                  mismatches;
	int                  tests_run;

	fma_unit dut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .order_code(order_code),
		.form(form), .dbl(dbl), .packed_op(packed_op), .wide(wide), .round_mode(round_mode),
		.src1_idx(i1), .src1(s1), .src2(s2), .src3(s3), .res_valid(res_valid),
		.res_dest_idx(res_dest_idx), .res_data(res_data), .invalid_operation_flag(flag));

	fma_rf_model rf (.clk(clk), .idx1(i1), .idx2(i2), .idx3(i3), .src1(s1), .src2(s2),
		.src3(s3), .wr_en(res_valid), .wr_idx(res_dest_idx), .wr_data(res_data));

	always #5 clk = ~clk;

	task automatic cmp_vec(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] ex);
		tests_run++;
		if (got !== ex) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic ex);
		tests_run++;
		if (got !== ex) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask

	// One operation: load operands, issue, judge result and write-back
	task automatic run(input logic [5:0] oc, input logic [1:0] fm, input logic [1:0] rm,
		input int db, input int pk, input int wd, input logic [VEC_W-1:0] a,
		input logic [VEC_W-1:0] b, input logic [VEC_W-1:0] c,
		input logic [VEC_W-1:0] ex, input int ef);
		@(posedge clk);
		rf.regs_ff[1] <= a;
		rf.regs_ff[2] <= b;
		rf.regs_ff[3] <= c;
		op_valid <= 1'h1;
		order_code <= oc;
		form <= fm;
		round_mode <= rm;
		dbl <= 1'(db);
		packed_op <= 1'(pk);
		wide <= 1'(wd);
		@(posedge clk);
		op_valid <= 1'h0;
		#1;
		cmp_bit(res_valid, 1'h1);
		cmp_vec(res_data, ex);
		cmp_vec(VEC_W'(res_dest_idx), VEC_W'(i1));
		cmp_bit(flag, 1'(ef));
		@(posedge clk);
		#1;
		cmp_bit(res_valid, 1'h0);
		cmp_bit(flag, 1'h0);
		cmp_vec(rf.regs_ff[1], ex);
	endtask

	task automatic t_order();
		run(6'h1e, FORM_MADD, RM_NEAR, 1, 1, 1, {4{D2}}, {4{D3}}, {4{D5}},
			{4{64'h402a000000000000}}, 0);
		run(6'h27, FORM_MADD, RM_NEAR, 1, 1, 1, {4{D2}}, {4{D3}}, {4{D5}},
			{4{64'h4026000000000000}}, 0);
		run(6'h2d, FORM_MADD, RM_NEAR, 1, 1, 1, {4{D2}}, {4{D3}}, {4{D5}},
			{4{64'h4031000000000000}}, 0);
		run(6'h18, FORM_MADD, RM_NEAR, 1, 1, 1, {4{D2}}, {4{D3}}, {4{D5}},
			{4{64'h4026000000000000}}, 0);
		$display("t_order done");
	endtask

	task automatic t_forms();
		logic [31:0] ev [4] = '{32'h41300000, 32'h3f800000, 32'hbf800000, 32'hc1300000};
		for (int f = 0; f < 4; f++) begin
			run(6'h1b, 2'(f), RM_NEAR, 0, 1, 1, {8{S2}}, {8{S3}}, {8{S5}},
				{8{ev[f]}}, 0);
		end
		run(6'h1b, FORM_MADD, RM_NEAR, 0, 1, 0, {8{S2}}, {8{S3}}, {8{S5}},
			{128'h0, {4{ev[0]}}}, 0);
		$display("t_forms done");
	endtask

	task automatic t_scalar();
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 0, 1, {D5, D5, D3, D2}, {4{D3}}, {4{D5}},
			{128'h0, D3, 64'h4026000000000000}, 0);
		run(6'h1b, FORM_MADD, RM_NEAR, 0, 0, 1, {8{S2}}, {8{S3}}, {8{S5}},
			{128'h0, {3{S2}}, 32'h41300000}, 0);
		$display("t_scalar done");
	endtask

	task automatic t_round();
		logic [63:0] ev [4] = '{DP_ONE, DP_ONE, DP_ONE_UP, DP_ONE};
		for (int m = 0; m < 4; m++) begin
			run(6'h1b, FORM_MADD, 2'(m), 1, 1, 1, {4{DP_ONE_UP}}, {4{DP_ONE_DN}}, '0,
				{4{ev[m]}}, 0);
		end
		run(6'h1b, FORM_MSUB, RM_NEAR, 1, 1, 1, {4{DP_ONE_UP}}, {4{DP_ONE_DN}},
			{4{DP_ONE}}, {4{64'h3c9ffffffffffffe}}, 0);
		run(6'h1b, 2'h2, RM_NEAR, 1, 1, 1, {4{DP_ONE}}, {4{DP_ONE}}, '0,
			{4{DP_NEG_ONE}}, 0);
		$display("t_round done");
	endtask

	task automatic t_nan();
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DSN}}, {4{DQN}}, {4{DP_ONE}},
			{4{64'h7ff8000000000001}}, 1);
		run(6'h27, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DSN}}, {4{DQN}}, {4{DP_ONE}},
			{4{DQN}}, 1);
		run(6'h1b, FORM_MSUB, RM_NEAR, 1, 1, 1, {4{DP_ONE}}, {4{DP_ONE}}, {4{DQN}},
			{4{DQN}}, 0);
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DP_ONE}}, {4{DSN}}, {4{DQN}},
			{4{64'h7ff8000000000001}}, 1);
		$display("t_nan done");
	endtask

	task automatic t_inf();
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DINF}}, {4{DINF}},
			{4{DP_NZERO | DINF}}, {4{DP_DNAN}}, 1);
		run(6'h1b, FORM_MSUB, RM_NEAR, 1, 1, 1, {4{DINF}}, {4{DP_ONE}},
			{4{DP_NZERO | DINF}}, {4{DINF}}, 0);
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DINF}}, '0, {4{DP_ONE}},
			{4{DP_DNAN}}, 1);
		$display("t_inf done");
	endtask

	task automatic t_zero();
		logic [VEC_W-1:0] nz;
		for (int m = 0; m < 4; m++) begin
			nz = (2'(m) == RM_DOWN) ? {4{DP_NZERO}} : '0;
			run(6'h1b, FORM_MADD, 2'(m), 1, 1, 1, '0, '0, '0, '0, 0);
			run(6'h1b, 2'h3, 2'(m), 1, 1, 1, '0, '0, '0, {4{DP_NZERO}}, 0);
			run(6'h1b, FORM_MSUB, 2'(m), 1, 1, 1, '0, '0, '0, nz, 0);
			run(6'h1b, FORM_MSUB, 2'(m), 1, 1, 1, {4{DP_ONE}}, {4{DP_ONE}}, {4{DP_ONE}},
				nz, 0);
		end
		$display("t_zero done");
	endtask

	// Reset in mid-run clears the result registers
	task automatic t_reset();
		run(6'h1b, FORM_MADD, RM_NEAR, 1, 1, 1, {4{DSN}}, {4{DP_ONE}}, {4{DP_ONE}},
			{4{64'h7ff8000000000001}}, 1);
		@(posedge clk);
		resetn <= 1'h0;
		@(posedge clk);
		#1;
		cmp_bit(res_valid, 1'h0);
		cmp_vec(res_data, '0);
		cmp_bit(flag, 1'h0);
		@(posedge clk);
		resetn <= 1'h1;
		$display("t_reset done");
	endtask

	task automatic results();
		$display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(WD_CYC * 10);
		mismatches++;
		results();
	end

	initial begin
		{clk, resetn, op_valid, dbl, packed_op, wide} = '0;
		{order_code, form, round_mode} = '0;
		{mismatches, tests_run} = '0;
		i1 = 5'h1;
		i2 = 5'h2;
		i3 = 5'h3;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		t_order();
		t_forms();
		t_scalar();
		t_round();
		t_nan();
		t_inf();
		t_zero();
		t_reset();
		results();
	end
endmodule
